/* src/arith_logic_string_decode.sv */
// How it works
// - D4 then 0A is bcd adjust after multiply, 19 clocks.
// - D5 then 0A is bcd adjust before divide, 15 clocks.
// - group opcode reg 110/111 divides: 29, 38, 35, 44 clocks.
// - 98 sign extends byte to word, no operands, 2 clocks.
// - 99 sign extends word to dword, no operands, 4 clocks.
// - and/or/xor register forms take modrm, 3 or 10 clocks.
// - flag-only and register form takes modrm, 3 or 10 clocks.
// - flag-only and immediate to r/m: reg 000, 1+w immediates, 4/10.
// - flag-only and with accumulator: no modrm, second immediate if word.
// - accumulator form takes 3 clocks for byte, 4 for word.
// - block copy 14 clocks, repeated 8+8n.
// - port input string 14 clocks, repeated 8+8n.
// - port output string 14 clocks, repeated 8+8n.
// - block compare 22 clocks, conditional repeat 5+22n.
// - block scan 15 clocks, conditional repeat 5+15n.
// - block load 12 clocks, repeated 6+11n.
// - block store 10 clocks, repeated 6+9n.
// - repeat prefix repeats string op, n from repeat count register.
`include "decode_defs.svh"
module arith_logic_string_decode (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   fetch_valid,
  input  wire logic [7:0]             fetch_byte,
  input  wire logic [15:0]            repeat_count_register,
  input  wire logic                   zero_flag,
  output logic                        fetch_ready,
  output logic                        busy,
  output logic                        done,
  output logic                        bad_opcode,
  output decode_pkg::op_class_type    op_class,
  output logic                        wide,
  output logic                        reg_is_dest,
  output logic                        mem_operand,
  output logic                        flag_only,
  output logic                        rep_active,
  output logic [7:0]                  modrm_byte,
  output logic [15:0]                 immediate,
  output logic [15:0]                 elements_left
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE, ST_CONST, ST_MODRM, ST_IMM_LO, ST_IMM_HI, ST_EXEC, ST_SETUP, ST_ELEM
  } state_type;

  state_type                state_q;
  state_type                state_d;
  logic [7:0]               opcode_q;
  logic [7:0]               modrm_q;
  logic [15:0]              imm_q;
  logic [15:0]              count_q;
  logic                     rep_q;
  logic                     rep_z_q;
  logic                     fetch_ready_q;
  logic                     busy_q;
  logic                     done_q;
  logic                     bad_q;
  decode_pkg::op_class_type op_class_q;
  logic                     wide_q;
  logic                     reg_is_dest_q;
  logic                     mem_operand_q;
  logic                     flag_only_q;
  logic                     rep_active_q;
  logic                     take;
  logic [7:0]               opc_sel;
  logic [7:0]               modrm_sel;
  decode_pkg::op_class_type c_cls;
  logic                     c_const;
  logic                     c_modrm;
  logic [1:0]               c_imm;
  logic                     c_string;
  logic [5:0]               c_clocks;
  logic [5:0]               c_setup;
  logic [5:0]               c_per;
  logic                     go;
  logic                     reload;
  logic                     finish;
  logic                     bad;
  logic                     elem_end;
  logic                     cond_stop;
  logic                     tmr_load;
  logic [5:0]               tmr_val;
  logic                     tmr_last;

  assign take      = fetch_valid && fetch_ready_q;
  assign opc_sel   = (state_q == ST_OPCODE) ? fetch_byte : opcode_q;
  assign modrm_sel = (state_q == ST_MODRM) ? fetch_byte : modrm_q;

  opcode_classify u_classify (
    .opcode      (opc_sel),
    .modrm       (modrm_sel),
    .cls         (c_cls),
    .needs_const (c_const),
    .needs_modrm (c_modrm),
    .imm_bytes   (c_imm),
    .string_op   (c_string),
    .clocks      (c_clocks),
    .rep_setup   (c_setup),
    .rep_per     (c_per)
  );

  cycle_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .last     (tmr_last)
  );

  // only compare and scan look at the zero flag, sampled in an element's last cycle
  assign cond_stop = (op_class_q == decode_pkg::OP_COMPARE || op_class_q == decode_pkg::OP_SCAN) &&
                     (zero_flag != rep_z_q);

  always_comb begin
    state_d  = state_q;
    go       = 1'b0;
    reload   = 1'b0;
    finish   = 1'b0;
    bad      = 1'b0;
    elem_end = 1'b0;
    unique case (state_q)
      ST_OPCODE: begin
        if (take) begin
          if (fetch_byte[7:1] == `OPC_REP_PREFIX && !rep_q) begin
            state_d = ST_OPCODE;
          end else if ((c_cls == decode_pkg::OP_ILLEGAL && !c_modrm) || (rep_q && !c_string)) begin
            bad = 1'b1;
          end else if (c_const) begin
            state_d = ST_CONST;
          end else if (c_modrm) begin
            state_d = ST_MODRM;
          end else if (c_imm != 2'h0) begin
            state_d = ST_IMM_LO;
          end else begin
            go = 1'b1;
          end
        end
      end
      ST_CONST: begin
        if (take) begin
          if (fetch_byte == `BCD_CONST) begin
            go = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          if (c_cls == decode_pkg::OP_ILLEGAL) begin
            bad = 1'b1;
          end else if (c_imm != 2'h0) begin
            state_d = ST_IMM_LO;
          end else begin
            go = 1'b1;
          end
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          if (c_imm == `IMM_TWO) begin
            state_d = ST_IMM_HI;
          end else begin
            go = 1'b1;
          end
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          go = 1'b1;
        end
      end
      ST_EXEC: begin
        finish = tmr_last;
      end
      ST_SETUP: begin
        if (tmr_last) begin
          if (count_q == 16'h0000) begin
            finish = 1'b1;
          end else begin
            state_d = ST_ELEM;
            reload  = 1'b1;
          end
        end
      end
      ST_ELEM: begin
        if (tmr_last) begin
          elem_end = 1'b1;
          if (count_q == 16'h0001 || cond_stop) begin
            finish = 1'b1;
          end else begin
            reload = 1'b1;
          end
        end
      end
    endcase
    if (go) begin
      state_d = rep_q ? ST_SETUP : ST_EXEC;
    end
    if (finish || bad) begin
      state_d = ST_OPCODE;
    end
  end

  assign tmr_load = go || reload;
  // a phase is timed from the clock figure of the state being entered
  assign tmr_val  = (state_d == ST_SETUP) ? c_setup : (state_d == ST_ELEM) ? c_per : c_clocks;

  // ----------------------------------------
  // sequencing state
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OPCODE;
    end else begin
      state_q <= state_d;
    end
  end

  // ready is registered from the next state so the queue never sees a combinational path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ready_q <= 1'b0;
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
      bad_q         <= 1'b0;
    end else begin
      fetch_ready_q <= (state_d == ST_OPCODE) || (state_d == ST_CONST) || (state_d == ST_MODRM) ||
                       (state_d == ST_IMM_LO) || (state_d == ST_IMM_HI);
      busy_q        <= (state_d == ST_EXEC) || (state_d == ST_SETUP) || (state_d == ST_ELEM);
      done_q        <= finish;
      bad_q         <= bad;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_q <= 8'h00;
      modrm_q  <= 8'h00;
      imm_q    <= 16'h0000;
    end else if (take) begin
      if (state_q == ST_OPCODE) begin
        opcode_q <= fetch_byte;
        imm_q    <= 16'h0000;
      end
      if (state_q == ST_MODRM) begin
        modrm_q <= fetch_byte;
      end
      if (state_q == ST_IMM_LO) begin
        imm_q[7:0] <= fetch_byte;
      end
      if (state_q == ST_IMM_HI) begin
        imm_q[15:8] <= fetch_byte;
      end
    end
  end

  // a prefix stays armed until its instruction ends or is rejected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_q   <= 1'b0;
      rep_z_q <= 1'b0;
    end else if (finish || bad) begin
      rep_q <= 1'b0;
    end else if (state_q == ST_OPCODE && take && fetch_byte[7:1] == `OPC_REP_PREFIX && !rep_q) begin
      rep_q   <= 1'b1;
      rep_z_q <= fetch_byte[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
    end else if (go && rep_q) begin
      count_q <= repeat_count_register;
    end else if (elem_end) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // decoded attributes, held until the next instruction starts
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_class_q    <= decode_pkg::OP_NONE;
      wide_q        <= 1'b0;
      reg_is_dest_q <= 1'b0;
      mem_operand_q <= 1'b0;
      flag_only_q   <= 1'b0;
      rep_active_q  <= 1'b0;
    end else if (go) begin
      op_class_q    <= c_cls;
      wide_q        <= opc_sel[0] && !c_const;
      reg_is_dest_q <= opc_sel[1] && (c_cls == decode_pkg::OP_AND || c_cls == decode_pkg::OP_OR ||
                                      c_cls == decode_pkg::OP_XOR);
      mem_operand_q <= c_modrm && (modrm_sel[7:6] != `MOD_REG);
      flag_only_q   <= (c_cls == decode_pkg::OP_TEST_RM) || (c_cls == decode_pkg::OP_TEST_IMM) ||
                       (c_cls == decode_pkg::OP_TEST_ACC);
      rep_active_q  <= rep_q;
    end
  end

  assign fetch_ready   = fetch_ready_q;
  assign busy          = busy_q;
  assign done          = done_q;
  assign bad_opcode    = bad_q;
  assign op_class      = op_class_q;
  assign wide          = wide_q;
  assign reg_is_dest   = reg_is_dest_q;
  assign mem_operand   = mem_operand_q;
  assign flag_only     = flag_only_q;
  assign rep_active    = rep_active_q;
  assign modrm_byte    = modrm_q;
  assign immediate     = imm_q;
  assign elements_left = count_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [23:0] busy_len_q;
  logic        was_busy_q;
  logic [15:0] start_n_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_q <= 24'h000000;
      was_busy_q <= 1'b0;
      start_n_q  <= 16'h0000;
    end else begin
      was_busy_q <= busy_q;
      if (busy_q && !was_busy_q) begin
        busy_len_q <= 24'h000001;
      end else if (busy_q) begin
        busy_len_q <= busy_len_q + 24'h000001;
      end
      if (go && rep_q) begin
        start_n_q <= repeat_count_register;
      end
    end
  end

  sequence s_b2w_taken;
    state_q == ST_OPCODE && take && fetch_byte == `OPC_B2W && !rep_q;
  endsequence

  sequence s_w2d_taken;
    state_q == ST_OPCODE && take && fetch_byte == `OPC_W2D && !rep_q;
  endsequence

  property p_bcd_mul;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && op_class_q == decode_pkg::OP_BCD_MUL |-> busy_len_q == 24'(`CLK_BCD_MUL);
  endproperty
  a_bcd_mul: assert property (p_bcd_mul) else $error("bcd multiply adjust clock count wrong");

  property p_bcd_div;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && op_class_q == decode_pkg::OP_BCD_DIV |-> busy_len_q == 24'(`CLK_BCD_DIV);
  endproperty
  a_bcd_div: assert property (p_bcd_div) else $error("bcd divide adjust clock count wrong");

  property p_bad_const;
    @(posedge core_clk) disable iff (!rst_n)
      state_q == ST_CONST && take && fetch_byte != `BCD_CONST |=> bad_q && !busy_q;
  endproperty
  a_bad_const: assert property (p_bad_const) else $error("bad adjust constant not rejected");

  property p_quot;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && (op_class_q == decode_pkg::OP_UQUOT || op_class_q == decode_pkg::OP_SQUOT) |->
      busy_len_q == 24'(mem_operand_q ? (wide_q ? `CLK_QUOT_MW : `CLK_QUOT_MB) :
                                        (wide_q ? `CLK_QUOT_RW : `CLK_QUOT_RB));
  endproperty
  a_quot: assert property (p_quot) else $error("divide clock count wrong");

  property p_b2w;
    @(posedge core_clk) disable iff (!rst_n)
      s_b2w_taken |=> busy_q [*2] ##1 (done_q && !busy_q);
  endproperty
  a_b2w: assert property (p_b2w) else $error("byte sign extend timing wrong");

  property p_w2d;
    @(posedge core_clk) disable iff (!rst_n)
      s_w2d_taken |=> busy_q [*4] ##1 (done_q && !busy_q);
  endproperty
  a_w2d: assert property (p_w2d) else $error("word sign extend timing wrong");

  property p_logic;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && (op_class_q == decode_pkg::OP_AND || op_class_q == decode_pkg::OP_OR ||
                 op_class_q == decode_pkg::OP_XOR || op_class_q == decode_pkg::OP_TEST_RM) |->
      busy_len_q == 24'(mem_operand_q ? `CLK_LOGIC_MEM : `CLK_LOGIC_REG);
  endproperty
  a_logic: assert property (p_logic) else $error("logic op clock count wrong");

  property p_acc;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && op_class_q == decode_pkg::OP_TEST_ACC |->
      busy_len_q == 24'(wide_q ? `CLK_ACC_WORD : `CLK_ACC_BYTE);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator form clock count wrong");

  property p_copy_rep;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && op_class_q == decode_pkg::OP_COPY && rep_active_q |->
      busy_len_q == 24'(`REP_SETUP_MOVE) + 24'(`REP_PER_MOVE) * 24'(start_n_q);
  endproperty
  a_copy_rep: assert property (p_copy_rep) else $error("repeated copy clock count wrong");

  property p_compare_rep;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && op_class_q == decode_pkg::OP_COMPARE && rep_active_q |->
      busy_len_q == 24'(`REP_SETUP_COND) + 24'(`CLK_COMPARE) * 24'(start_n_q - count_q);
  endproperty
  a_compare_rep: assert property (p_compare_rep) else $error("repeated compare clock count wrong");
endmodule

/* src/decode_defs.svh */
`ifndef DECODE_DEFS_SVH
`define DECODE_DEFS_SVH
// ----------------------------------------
// opcode encodings
// ----------------------------------------
`define OPC_BCD_MUL      8'hD4
`define OPC_BCD_DIV      8'hD5
`define BCD_CONST        8'h0A
`define OPC_B2W          8'h98
`define OPC_W2D          8'h99
`define OPC_AND_RM       6'h08
`define OPC_OR_RM        6'h02
`define OPC_XOR_RM       6'h0C
`define OPC_TEST_RM      7'h42
`define OPC_GROUP        7'h7B
`define OPC_TEST_ACC     7'h54
`define OPC_COPY         7'h52
`define OPC_PORT_IN      7'h36
`define OPC_PORT_OUT     7'h37
`define OPC_COMPARE      7'h53
`define OPC_SCAN         7'h57
`define OPC_LOAD         7'h56
`define OPC_STORE        7'h55
`define OPC_REP_PREFIX   7'h79
`define REG_TEST         3'h0
`define REG_UQUOT        3'h6
`define REG_SQUOT        3'h7
`define MOD_REG          2'h3
`define IMM_ONE          2'h1
`define IMM_TWO          2'h2
// ----------------------------------------
// clock counts
// ----------------------------------------
`define CLK_BCD_MUL      6'h13
`define CLK_BCD_DIV      6'h0F
`define CLK_B2W          6'h02
`define CLK_W2D          6'h04
`define CLK_QUOT_RB      6'h1D
`define CLK_QUOT_RW      6'h26
`define CLK_QUOT_MB      6'h23
`define CLK_QUOT_MW      6'h2C
`define CLK_LOGIC_REG    6'h03
`define CLK_LOGIC_MEM    6'h0A
`define CLK_TIMM_REG     6'h04
`define CLK_TIMM_MEM     6'h0A
`define CLK_ACC_BYTE     6'h03
`define CLK_ACC_WORD     6'h04
`define CLK_COPY         6'h0E
`define CLK_PORT         6'h0E
`define CLK_COMPARE      6'h16
`define CLK_SCAN         6'h0F
`define CLK_LOAD         6'h0C
`define CLK_STORE        6'h0A
`define REP_SETUP_MOVE   6'h08
`define REP_SETUP_COND   6'h05
`define REP_SETUP_ACC    6'h06
`define REP_PER_MOVE     6'h08
`define REP_PER_LOAD     6'h0B
`define REP_PER_STORE    6'h09
`endif

/* src/decode_pkg.sv */
package decode_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_BCD_MUL, OP_BCD_DIV, OP_UQUOT, OP_SQUOT, OP_B2W, OP_W2D,
    OP_AND, OP_OR, OP_XOR, OP_TEST_RM, OP_TEST_IMM, OP_TEST_ACC,
    OP_COPY, OP_PORT_IN, OP_PORT_OUT, OP_COMPARE, OP_SCAN, OP_LOAD, OP_STORE, OP_ILLEGAL
  } op_class_type;
endpackage

/* src/cycle_timer.sv */
module cycle_timer (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [5:0] load_val,
  output logic            last
);
  logic [5:0] cnt_q;

  // phase lasts load_val cycles; last marks the final one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end

  assign last = (cnt_q == 6'h01);
endmodule

/* src/opcode_classify.sv */
`include "decode_defs.svh"
module opcode_classify (
  input  wire logic [7:0]             opcode,
  input  wire logic [7:0]             modrm,
  output decode_pkg::op_class_type    cls,
  output logic                        needs_const,
  output logic                        needs_modrm,
  output logic [1:0]                  imm_bytes,
  output logic                        string_op,
  output logic [5:0]                  clocks,
  output logic [5:0]                  rep_setup,
  output logic [5:0]                  rep_per
);
  logic mem;
  logic w;

  assign mem = (modrm[7:6] != `MOD_REG);
  assign w   = opcode[0];

  always_comb begin
    cls         = decode_pkg::OP_ILLEGAL;
    needs_const = 1'b0;
    needs_modrm = 1'b0;
    imm_bytes   = 2'h0;
    string_op   = 1'b0;
    clocks      = `CLK_B2W;
    rep_setup   = `REP_SETUP_MOVE;
    rep_per     = `REP_PER_MOVE;
    if (opcode == `OPC_BCD_MUL) begin
      cls = decode_pkg::OP_BCD_MUL; needs_const = 1'b1; clocks = `CLK_BCD_MUL;
    end else if (opcode == `OPC_BCD_DIV) begin
      cls = decode_pkg::OP_BCD_DIV; needs_const = 1'b1; clocks = `CLK_BCD_DIV;
    end else if (opcode == `OPC_B2W) begin
      cls = decode_pkg::OP_B2W; clocks = `CLK_B2W;
    end else if (opcode == `OPC_W2D) begin
      cls = decode_pkg::OP_W2D; clocks = `CLK_W2D;
    end else if (opcode[7:2] == `OPC_AND_RM || opcode[7:2] == `OPC_OR_RM || opcode[7:2] == `OPC_XOR_RM) begin
      cls = (opcode[7:2] == `OPC_AND_RM) ? decode_pkg::OP_AND :
            (opcode[7:2] == `OPC_OR_RM) ? decode_pkg::OP_OR : decode_pkg::OP_XOR;
      needs_modrm = 1'b1;
      clocks = mem ? `CLK_LOGIC_MEM : `CLK_LOGIC_REG;
    end else if (opcode[7:1] == `OPC_TEST_RM) begin
      cls = decode_pkg::OP_TEST_RM; needs_modrm = 1'b1;
      clocks = mem ? `CLK_LOGIC_MEM : `CLK_LOGIC_REG;
    end else if (opcode[7:1] == `OPC_GROUP) begin
      needs_modrm = 1'b1;
      if (modrm[5:3] == `REG_TEST) begin
        cls = decode_pkg::OP_TEST_IMM;
        imm_bytes = w ? `IMM_TWO : `IMM_ONE;
        clocks = mem ? `CLK_TIMM_MEM : `CLK_TIMM_REG;
      end else if (modrm[5:3] == `REG_UQUOT || modrm[5:3] == `REG_SQUOT) begin
        cls = (modrm[5:3] == `REG_UQUOT) ? decode_pkg::OP_UQUOT : decode_pkg::OP_SQUOT;
        clocks = mem ? (w ? `CLK_QUOT_MW : `CLK_QUOT_MB) : (w ? `CLK_QUOT_RW : `CLK_QUOT_RB);
      end
    end else if (opcode[7:1] == `OPC_TEST_ACC) begin
      cls = decode_pkg::OP_TEST_ACC;
      imm_bytes = w ? `IMM_TWO : `IMM_ONE;
      clocks = w ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
    end else begin
      string_op = 1'b1;
      unique case (opcode[7:1])
        `OPC_COPY:     begin cls = decode_pkg::OP_COPY; clocks = `CLK_COPY; end
        `OPC_PORT_IN:  begin cls = decode_pkg::OP_PORT_IN; clocks = `CLK_PORT; end
        `OPC_PORT_OUT: begin cls = decode_pkg::OP_PORT_OUT; clocks = `CLK_PORT; end
        `OPC_COMPARE: begin
          cls = decode_pkg::OP_COMPARE; clocks = `CLK_COMPARE;
          rep_setup = `REP_SETUP_COND; rep_per = `CLK_COMPARE;
        end
        `OPC_SCAN: begin
          cls = decode_pkg::OP_SCAN; clocks = `CLK_SCAN;
          rep_setup = `REP_SETUP_COND; rep_per = `CLK_SCAN;
        end
        `OPC_LOAD: begin
          cls = decode_pkg::OP_LOAD; clocks = `CLK_LOAD;
          rep_setup = `REP_SETUP_ACC; rep_per = `REP_PER_LOAD;
        end
        `OPC_STORE: begin
          cls = decode_pkg::OP_STORE; clocks = `CLK_STORE;
          rep_setup = `REP_SETUP_ACC; rep_per = `REP_PER_STORE;
        end
        default: string_op = 1'b0;
      endcase
    end
  end
endmodule

/* dv/prefetch_model.sv */
module prefetch_model (
  input  wire logic       core_clk,
  input  wire logic       fetch_ready,
  output logic            fetch_valid,
  output logic [7:0]      fetch_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q_bytes[$];
  // idle byte flips every cycle so a stale value is never mistaken for data
  initial begin
    fetch_valid = 1'b0;
    fetch_byte  = 8'hFF;
  end
  task automatic push(input logic [7:0] b);
    q_bytes.push_back(b);
  endtask
  always @(posedge core_clk) begin
    if (fetch_valid && fetch_ready) begin
      void'(q_bytes.pop_front());
    end
    #1;
    fetch_valid = q_bytes.size() > 0;
    fetch_byte  = fetch_valid ? q_bytes[0] : ~fetch_byte;
  end
endmodule

/* dv/arith_logic_string_decode_bench.sv */
module arith_logic_string_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        fetch_valid, fetch_ready, busy, done, bad_opcode, wide, reg_is_dest;
  logic        mem_operand, flag_only, rep_active;
  logic [7:0]  fetch_byte, modrm_byte;
  logic [15:0] count_n = 16'h0002;
  logic        zf      = 1'b1;
  logic [15:0] immediate, elements_left;
  decode_pkg::op_class_type op_class;
  int          fail_count = 0;
  int          check_count = 0;
  always #2 core_clk = ~core_clk;
  prefetch_model q (.core_clk(core_clk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte));
  arith_logic_string_decode uut (.core_clk(core_clk), .arst_n(arst_n), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .repeat_count_register(count_n), .zero_flag(zf),
    .fetch_ready(fetch_ready), .busy(busy), .done(done), .bad_opcode(bad_opcode),
    .op_class(op_class), .wide(wide), .reg_is_dest(reg_is_dest), .mem_operand(mem_operand),
    .flag_only(flag_only), .rep_active(rep_active), .modrm_byte(modrm_byte),
    .immediate(immediate), .elements_left(elements_left));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // busy must last exactly the clock count, and done must be high once busy drops
  task automatic run(input int nb, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input int k, input decode_pkg::op_class_type c);
    int n;
    q.push(b0);
    if (nb > 1) q.push(b1);
    if (nb > 2) q.push(b2);
    n = 0;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge core_clk) #1;
    while (busy === 1'b1 && n < 99) begin
      n++;
      @(posedge core_clk) #1;
    end
    chk(n, k);
    chk(done, 1'b1);
    chk(op_class, c);
  endtask
  initial begin
    #20000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1'b1;
    run(2, 8'hD4, 8'h0A, 8'h00, 19, decode_pkg::OP_BCD_MUL);
    run(2, 8'hD5, 8'h0A, 8'h00, 15, decode_pkg::OP_BCD_DIV);
    run(2, 8'hF6, 8'hF0, 8'h00, 29, decode_pkg::OP_UQUOT);
    run(2, 8'hF7, 8'hF8, 8'h00, 38, decode_pkg::OP_SQUOT);
    run(2, 8'hF6, 8'h30, 8'h00, 35, decode_pkg::OP_UQUOT);
    run(2, 8'hF7, 8'h38, 8'h00, 44, decode_pkg::OP_SQUOT);
    run(1, 8'h98, 8'h00, 8'h00, 2, decode_pkg::OP_B2W);
    chk(fetch_ready, 1'b1);
    run(1, 8'h99, 8'h00, 8'h00, 4, decode_pkg::OP_W2D);
    run(2, 8'h20, 8'hC0, 8'h00, 3, decode_pkg::OP_AND);
    run(2, 8'h31, 8'hC0, 8'h00, 3, decode_pkg::OP_XOR);
    run(2, 8'h0A, 8'h00, 8'h00, 10, decode_pkg::OP_OR);
    chk({reg_is_dest, mem_operand, wide}, 3'h6);
    run(2, 8'h84, 8'hC8, 8'h00, 3, decode_pkg::OP_TEST_RM);
    chk(modrm_byte, 8'hC8);
    chk(flag_only, 1'b1);
    run(3, 8'hF6, 8'h00, 8'h12, 10, decode_pkg::OP_TEST_IMM);
    chk(immediate, 16'h0012);
    run(2, 8'hA8, 8'h55, 8'h00, 3, decode_pkg::OP_TEST_ACC);
    run(3, 8'hA9, 8'h34, 8'h12, 4, decode_pkg::OP_TEST_ACC);
    chk({wide, immediate}, 17'h11234);
    run(1, 8'hA4, 8'h00, 8'h00, 14, decode_pkg::OP_COPY);
    run(1, 8'h6C, 8'h00, 8'h00, 14, decode_pkg::OP_PORT_IN);
    run(1, 8'h6E, 8'h00, 8'h00, 14, decode_pkg::OP_PORT_OUT);
    run(1, 8'hA6, 8'h00, 8'h00, 22, decode_pkg::OP_COMPARE);
    run(1, 8'hAE, 8'h00, 8'h00, 15, decode_pkg::OP_SCAN);
    run(1, 8'hAC, 8'h00, 8'h00, 12, decode_pkg::OP_LOAD);
    run(1, 8'hAA, 8'h00, 8'h00, 10, decode_pkg::OP_STORE);
    run(2, 8'hF2, 8'hA4, 8'h00, 24, decode_pkg::OP_COPY);
    chk({rep_active, elements_left}, 17'h10000);
    run(2, 8'hF2, 8'h6C, 8'h00, 24, decode_pkg::OP_PORT_IN);
    run(2, 8'hF2, 8'h6E, 8'h00, 24, decode_pkg::OP_PORT_OUT);
    run(2, 8'hF3, 8'hA6, 8'h00, 49, decode_pkg::OP_COMPARE);
    run(2, 8'hF3, 8'hAE, 8'h00, 35, decode_pkg::OP_SCAN);
    run(2, 8'hF2, 8'hAC, 8'h00, 28, decode_pkg::OP_LOAD);
    run(2, 8'hF2, 8'hAA, 8'h00, 24, decode_pkg::OP_STORE);
    run(2, 8'hF2, 8'hA6, 8'h00, 27, decode_pkg::OP_COMPARE);
    chk(elements_left, 16'h0001);
    zf = 1'b0;
    run(2, 8'hF3, 8'hAE, 8'h00, 20, decode_pkg::OP_SCAN);
    chk(elements_left, 16'h0001);
    count_n = 16'h0000;
    run(2, 8'hF2, 8'hA4, 8'h00, 8, decode_pkg::OP_COPY);
    q.push(8'hD4);
    q.push(8'h0B);
    for (int i = 0; i < 20 && bad_opcode !== 1'b1; i++) @(posedge core_clk) #1;
    chk(bad_opcode, 1'b1);
    q.push(8'hF2);
    q.push(8'h98);
    @(posedge core_clk) #1;
    for (int i = 0; i < 20 && bad_opcode !== 1'b1; i++) @(posedge core_clk) #1;
    chk(bad_opcode, 1'b1);
    test_done;
  end
endmodule
